// File: design/scfm_core.sv
// command-code translator and integer-file map over a word database
// assumes requests come from logic on ref_clk, one per cycle at most
//
// Functional notes
// RL1 - basic codes map to single command bytes
// RL2 - word-range codes send 0x0f plus function
// RL3 - typed logical codes send 0x0f plus function
// RL4 - record splits into module and device parts
// RL5 - emulated files overlay the same database
// RL6 - word is (file-first) times size plus element
// RL7 - remote master addresses by file and element
// RL8 - words 0 to 4999 are user data
// RL9 - higher words map to fixed areas
// RL10 - remote host reaches every database area
// RL11 - change-only writes skipped when data unchanged
// RL12 - first file 0-100, size 1-1000
// RL13 - unknown codes rejected and flagged as error
// RL14 - words beyond 9999 answer address error
`timescale 1ns/1ps
`default_nettype none
`include "scfm_params.svh"
module scfm_core #(
  parameter int DB_WORDS = `SCFM_DB_WORDS
) (
  input wire logic ref_clk, // 40 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire logic cmdValid, // command record presented
  input wire logic [9:0] cmdCode, // module function code
  input wire logic [1:0] cmdEnable, // enable code of the record
  input wire logic cmdChanged, // write data changed since last sent
  input wire logic [15:0] cmdIntAddr, // module part: internal address
  input wire logic [15:0] cmdCount, // module part: word count
  input wire logic [7:0] cmdNode, // device part: node address
  input wire logic [7:0] cmdFile, // device part: file number
  input wire logic [9:0] cmdElem, // device part: element
  output logic reqValid, // translated request pulse
  output logic [7:0] reqCmd, // serial command byte
  output logic [7:0] reqFunc, // serial function byte
  output logic reqHasFunc, // function byte is meaningful
  output logic reqAscii, // ascii addressing form
  output logic reqThree, // three address fields
  output logic reqWrite, // request writes the slave
  output logic [15:0] reqIntAddr, // module part copy
  output logic [15:0] reqCount, // module part copy
  output logic [7:0] reqNode, // device part copy
  output logic [7:0] reqFile, // device part copy
  output logic [9:0] reqElem, // device part copy
  output logic cmdSkip, // unchanged write skipped pulse
  output logic cmdError, // unsupported code pulse
  input wire logic [6:0] firstFile, // first emulated file number
  input wire logic [9:0] fileSize, // words per emulated file
  input wire logic accValid, // remote file access request
  input wire logic accWrite, // access is a write
  input wire logic [7:0] accFile, // remote file number
  input wire logic [9:0] accElem, // remote element index
  input wire logic [15:0] accWdata, // remote write data
  output logic accDone, // remote access answered pulse
  output logic accErr, // address error with accDone
  output logic [3:0] accRegion, // database area of the access
  output logic [17:0] accWord, // computed database word
  output logic [15:0] accRdata, // remote read data
  input wire logic dbValid, // internal direct access
  input wire logic dbWrite, // internal access is a write
  input wire logic [13:0] dbAddr, // internal word address
  input wire logic [15:0] dbWdata, // internal write data
  output logic [15:0] dbRdata // internal read data
);
  // ======================================================
  // elaboration checks
  if (DB_WORDS < 1 || DB_WORDS > `SCFM_DB_WORDS) begin : g_bad_words
    $error("DB_WORDS out of range");
  end

  // ======================================================
  // code lookup: {ok, write, three, ascii, hasFunc, cmd, func}
  function automatic logic [20:0] lookup(input logic [9:0] code);
    logic [20:0] r;
    r = '0;
    case (code)
      // RL1 basic byte map
      `SCFM_FC_PWRITE: r = {5'h18, `SCFM_CB_PWRITE, 8'h00};
      `SCFM_FC_UREAD: r = {5'h10, `SCFM_CB_UREAD, 8'h00};
      `SCFM_FC_PBITWR: r = {5'h18, `SCFM_CB_PBITWR, 8'h00};
      `SCFM_FC_UBITWR: r = {5'h18, `SCFM_CB_UBITWR, 8'h00};
      `SCFM_FC_UWRITE: r = {5'h18, `SCFM_CB_UWRITE, 8'h00};
      // RL2 word range set
      `SCFM_FC_RNGWR_B: r = {5'h19, `SCFM_CB_EXT, `SCFM_FB_RNGWR};
      `SCFM_FC_RNGRD_B: r = {5'h11, `SCFM_CB_EXT, `SCFM_FB_RNGRD};
      `SCFM_FC_RMW_B: r = {5'h19, `SCFM_CB_EXT, `SCFM_FB_RMW};
      `SCFM_FC_RNGWR_A: r = {5'h1b, `SCFM_CB_EXT, `SCFM_FB_RNGWR};
      `SCFM_FC_RNGRD_A: r = {5'h13, `SCFM_CB_EXT, `SCFM_FB_RNGRD};
      `SCFM_FC_RMW_A: r = {5'h1b, `SCFM_CB_EXT, `SCFM_FB_RMW};
      // RL3 typed logical set
      `SCFM_FC_TRD2: r = {5'h11, `SCFM_CB_EXT, `SCFM_FB_TRD2};
      `SCFM_FC_TRD3: r = {5'h15, `SCFM_CB_EXT, `SCFM_FB_TRD3};
      `SCFM_FC_TWR2: r = {5'h19, `SCFM_CB_EXT, `SCFM_FB_TWR2};
      `SCFM_FC_TWR3: r = {5'h1d, `SCFM_CB_EXT, `SCFM_FB_TWR3};
      `SCFM_FC_TWRM: r = {5'h1d, `SCFM_CB_EXT, `SCFM_FB_TWRM};
      default: r = '0;
    endcase
    return r;
  endfunction

  // ======================================================
  // database area of a word
  function automatic scfm_pkg::scfm_region_t area(input logic [17:0] w);
    scfm_pkg::scfm_region_t a;
    a = scfm_pkg::REG_NONE;
    // RL8 user words below first area
    if (w < `SCFM_BASE_BPCFG) a = scfm_pkg::REG_USER;
    else if (w < `SCFM_BASE_P1SET) a = scfm_pkg::REG_BPCFG;
    else if (w < `SCFM_BASE_P2SET) a = scfm_pkg::REG_P1SET;
    else if (w < `SCFM_BASE_RSV1) a = scfm_pkg::REG_P2SET;
    else if (w < `SCFM_BASE_P1CMD) a = scfm_pkg::REG_RSV1;
    else if (w < `SCFM_BASE_P2CMD) a = scfm_pkg::REG_P1CMD;
    else if (w < `SCFM_BASE_STAT) a = scfm_pkg::REG_P2CMD;
    else if (w < `SCFM_BASE_CCTL) a = scfm_pkg::REG_STAT;
    else if (w < `SCFM_BASE_RSV2) a = scfm_pkg::REG_CCTL;
    else if (w <= `SCFM_WORD_MAX) a = scfm_pkg::REG_RSV2;
    return a;
  endfunction

  // ======================================================
  // state and combinational next state
  scfm_pkg::scfm_state_t st;
  scfm_pkg::scfm_state_t next_st;
  logic [20:0] lk;
  logic [17:0] word;
  logic [6:0] fSel;
  logic [9:0] sSel;
  logic addrOk;
  logic memWrite;
  logic [13:0] memAddr;

  // RL12 settings out of range fall back to defaults
  assign fSel = (firstFile > `SCFM_FIRST_FILE_MAX) ?
                `SCFM_FIRST_FILE_DEF : firstFile;
  assign sSel = (fileSize < `SCFM_FILE_SIZE_MIN ||
                 fileSize > `SCFM_FILE_SIZE_MAX) ?
                `SCFM_FILE_SIZE_DEF : fileSize;
  assign lk = lookup(cmdCode);
  // RL6 file to word arithmetic
  assign word = (18'(accFile) - 18'(fSel)) * 18'(sSel) + 18'(accElem);
  // RL14 beyond last word or below first file
  assign addrOk = (accFile >= {1'b0, fSel}) && (word <= `SCFM_WORD_MAX)
                  && (word < 18'(DB_WORDS));

  always_comb begin
    next_st = st;
    next_st.reqValid = 1'b0;
    next_st.cmdSkip = 1'b0;
    next_st.cmdError = 1'b0;
    next_st.accDone = 1'b0;
    next_st.accErr = 1'b0;
    if (cmdValid) begin
      // RL13 unsupported code rejected
      if (!lk[20]) begin
        next_st.cmdError = 1'b1;
      // RL11 unchanged write skipped
      end else if (lk[19] && cmdEnable == `SCFM_EN_ON_CHANGE &&
                   !cmdChanged) begin
        next_st.cmdSkip = 1'b1;
      end else begin
        next_st.reqValid = 1'b1;
        next_st.reqWrite = lk[19];
        next_st.reqThree = lk[18];
        next_st.reqAscii = lk[17];
        next_st.reqHasFunc = lk[16];
        next_st.reqCmd = lk[15:8];
        next_st.reqFunc = lk[7:0];
        // RL4 module part and device part
        next_st.reqIntAddr = cmdIntAddr;
        next_st.reqCount = cmdCount;
        next_st.reqNode = cmdNode;
        next_st.reqFile = cmdFile;
        next_st.reqElem = cmdElem;
      end
    end
    if (accValid) begin
      // RL9 area of every access
      next_st.accDone = 1'b1;
      next_st.accErr = !addrOk;
      next_st.accWord = word;
      next_st.accRegion = addrOk ? area(word) : scfm_pkg::REG_NONE;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.accRegion <= scfm_pkg::REG_NONE;
    end else begin
      st <= next_st;
    end
  end

  // ======================================================
  // shared word database
  logic [15:0] mem [DB_WORDS];
  // RL5 remote files overlay the database
  assign memWrite = (accValid && accWrite && addrOk) ||
                    (dbValid && dbWrite && !(accValid && accWrite) &&
                     {4'h0, dbAddr} < 18'(DB_WORDS));
  assign memAddr = (accValid && accWrite) ? word[13:0] : dbAddr;

  // RL10 remote reaches every area
  always_ff @(posedge ref_clk) begin
    if (memWrite) begin
      mem[memAddr] <= (accValid && accWrite) ? accWdata : dbWdata;
    end
  end

  // read ports, registered
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      accRdata <= 16'h0000;
      dbRdata <= 16'h0000;
    end else begin
      if (accValid && !accWrite && addrOk) accRdata <= mem[word[13:0]];
      if (dbValid && !dbWrite && {4'h0, dbAddr} < 18'(DB_WORDS)) begin
        dbRdata <= mem[dbAddr];
      end
    end
  end

  // ======================================================
  // outputs
  assign reqValid = st.reqValid;
  assign reqCmd = st.reqCmd;
  assign reqFunc = st.reqFunc;
  assign reqHasFunc = st.reqHasFunc;
  assign reqAscii = st.reqAscii;
  assign reqThree = st.reqThree;
  assign reqWrite = st.reqWrite;
  assign reqIntAddr = st.reqIntAddr;
  assign reqCount = st.reqCount;
  assign reqNode = st.reqNode;
  assign reqFile = st.reqFile;
  assign reqElem = st.reqElem;
  assign cmdSkip = st.cmdSkip;
  assign cmdError = st.cmdError;
  assign accDone = st.accDone;
  assign accErr = st.accErr;
  assign accRegion = st.accRegion;
  assign accWord = st.accWord;
endmodule // scfm_core
`default_nettype wire

// File: design/scfm_params.svh
// constants for the command-code translator and file map
// assumes inclusion by bare name from the design files
`ifndef SCFM_PARAMS_SVH
`define SCFM_PARAMS_SVH
// ======================================================
// module function codes
`define SCFM_FC_PWRITE 10'h001
`define SCFM_FC_UREAD 10'h002
`define SCFM_FC_PBITWR 10'h003
`define SCFM_FC_UBITWR 10'h004
`define SCFM_FC_UWRITE 10'h005
`define SCFM_FC_RNGWR_B 10'h064
`define SCFM_FC_RNGRD_B 10'h065
`define SCFM_FC_RMW_B 10'h066
`define SCFM_FC_RNGWR_A 10'h096
`define SCFM_FC_RNGRD_A 10'h097
`define SCFM_FC_RMW_A 10'h098
`define SCFM_FC_TRD2 10'h1f5
`define SCFM_FC_TRD3 10'h1f6
`define SCFM_FC_TWR2 10'h1fd
`define SCFM_FC_TWR3 10'h1fe
`define SCFM_FC_TWRM 10'h1ff
// ======================================================
// serial command and function bytes
`define SCFM_CB_PWRITE 8'h00
`define SCFM_CB_UREAD 8'h01
`define SCFM_CB_PBITWR 8'h02
`define SCFM_CB_UBITWR 8'h05
`define SCFM_CB_UWRITE 8'h08
`define SCFM_CB_EXT 8'h0f
`define SCFM_FB_RNGWR 8'h00
`define SCFM_FB_RNGRD 8'h01
`define SCFM_FB_RMW 8'h26
`define SCFM_FB_TRD2 8'ha1
`define SCFM_FB_TRD3 8'ha2
`define SCFM_FB_TWR2 8'ha9
`define SCFM_FB_TWR3 8'haa
`define SCFM_FB_TWRM 8'hab
`define SCFM_EN_ON_CHANGE 2'h2
// ======================================================
// file map settings and database layout
`define SCFM_FIRST_FILE_DEF 7'h07
`define SCFM_FIRST_FILE_MAX 7'h64
`define SCFM_FILE_SIZE_DEF 10'h0c8
`define SCFM_FILE_SIZE_MIN 10'h001
`define SCFM_FILE_SIZE_MAX 10'h3e8
`define SCFM_DB_WORDS 10000
`define SCFM_WORD_MAX 18'h0270f
`define SCFM_BASE_BPCFG 18'h01388
`define SCFM_BASE_P1SET 18'h01392
`define SCFM_BASE_P2SET 18'h013b0
`define SCFM_BASE_RSV1 18'h013ce
`define SCFM_BASE_P1CMD 18'h01450
`define SCFM_BASE_P2CMD 18'h01900
`define SCFM_BASE_STAT 18'h01db0
`define SCFM_BASE_CCTL 18'h01e78
`define SCFM_BASE_RSV2 18'h01f40
`endif

// File: design/scfm_pkg.sv
// types for the command-code translator and file map
// assumes scfm_params.svh is compiled alongside
`default_nettype none
package scfm_pkg;
  // ======================================================
  // database area that a file access lands in
  typedef enum logic [3:0] {
    REG_USER = 4'h0,
    REG_BPCFG = 4'h1,
    REG_P1SET = 4'h2,
    REG_P2SET = 4'h3,
    REG_RSV1 = 4'h4,
    REG_P1CMD = 4'h5,
    REG_P2CMD = 4'h6,
    REG_STAT = 4'h7,
    REG_CCTL = 4'h8,
    REG_RSV2 = 4'h9,
    REG_NONE = 4'hf
  } scfm_region_t;

  // registered state of the core except the read data and the database
  typedef struct packed {
    logic reqValid;
    logic [7:0] reqCmd;
    logic [7:0] reqFunc;
    logic reqHasFunc;
    logic reqAscii;
    logic reqThree;
    logic reqWrite;
    logic [15:0] reqIntAddr;
    logic [15:0] reqCount;
    logic [7:0] reqNode;
    logic [7:0] reqFile;
    logic [9:0] reqElem;
    logic cmdSkip;
    logic cmdError;
    logic accDone;
    logic accErr;
    scfm_region_t accRegion;
    logic [17:0] accWord;
  } scfm_state_t;
endpackage
`default_nettype wire

// File: tb/scfm_chk.sv
// assertions on the translator and file map ports
// assumes bound onto scfm_core, single clock
`timescale 1ns/1ps
`default_nettype none
module scfm_chk #(
  parameter int DB_WORDS = 10000
) (
  input wire logic ref_clk, // clock
  input wire logic rstn, // reset
  input wire logic cmdValid, // record
  input wire logic [9:0] cmdCode, // code
  input wire logic [1:0] cmdEnable, // enable
  input wire logic cmdChanged, // changed
  input wire logic [7:0] cmdNode, // node
  input wire logic reqValid, // request
  input wire logic [7:0] reqCmd, // command
  input wire logic [7:0] reqFunc, // function
  input wire logic reqHasFunc, // has function
  input wire logic [7:0] reqNode, // node copy
  input wire logic cmdSkip, // skip
  input wire logic cmdError, // error
  input wire logic [6:0] firstFile, // first file
  input wire logic [9:0] fileSize, // file size
  input wire logic accValid, // access
  input wire logic [7:0] accFile, // file
  input wire logic [9:0] accElem, // element
  input wire logic accDone, // done
  input wire logic accErr, // address error
  input wire logic [3:0] accRegion, // area
  input wire logic [17:0] accWord // word
);
  `include "scfm_exp.svh"
  // ==========
  // helpers
  logic okSet;
  logic [17:0] calc;
  // word from current settings
  assign okSet = firstFile <= 7'h64 && fileSize != 10'h000 &&
    fileSize <= 10'h3e8;
  assign calc = (18'(accFile) - 18'(firstFile)) * 18'(fileSize) +
    18'(accElem);
  default clocking dck @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ==========
  // assertions
  AST_ANSWER: assert property (cmdValid |=>
    $onehot({reqValid, cmdSkip, cmdError})) else $error("answer count");
  AST_BASIC: assert property (cmdValid && cmdCode >= 10'h001 &&
    cmdCode <= 10'h005 |=> cmdSkip || (reqValid && !reqHasFunc &&
    reqCmd == cbyt($past(cmdCode)))) else $error("basic byte");
  AST_RANGE: assert property (cmdValid && known(cmdCode) &&
    cmdCode inside {[10'h064:10'h098]} |=> cmdSkip || (reqCmd == 8'h0f
    && reqFunc == fbyt($past(cmdCode)))) else $error("range byte");
  AST_TYPED: assert property (cmdValid && known(cmdCode) &&
    cmdCode >= 10'h1f5 |=> cmdSkip || (reqValid && reqCmd == 8'h0f &&
    reqFunc == fbyt($past(cmdCode)))) else $error("typed byte");
  AST_UNKNOWN: assert property (cmdValid && !known(cmdCode) |=>
    cmdError && !reqValid) else $error("unknown code sent");
  AST_SKIP: assert property (cmdValid && cmdEnable == 2'h2 &&
    !cmdChanged && cmdCode == 10'h005 |=> cmdSkip ##0 !reqValid)
    else $error("unchanged write sent");
  AST_COPY: assert property (cmdValid ##1 reqValid |->
    reqNode == $past(cmdNode)) else $error("node copy");
  AST_WORD: assert property (accValid && okSet &&
    accFile >= 8'(firstFile) && calc <= 18'h0270f |=> accDone &&
    !accErr && accWord == $past(calc)) else $error("word calc");
  AST_ADDRERR: assert property (accValid && okSet &&
    (accFile < 8'(firstFile) || calc > 18'h0270f) |=> accDone &&
    accErr && accRegion == 4'hf) else $error("address error");
  AST_REGION: assert property (accDone && !accErr |->
    accRegion == rgn(accWord)) else $error("area");
  // main scenarios seen
  cover property (reqValid && reqHasFunc);
  cover property (cmdSkip);
  cover property (accDone && accErr);
endmodule // scfm_chk
bind scfm_core scfm_chk #(.DB_WORDS(DB_WORDS)) u_scfm_chk (.*);
`default_nettype wire

// File: tb/scfm_core_tb.sv
// self-checking bench for the translator and file map
// assumes scfm_remote on the access side, scfm_chk bound
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  mismatches++; $display("ERROR %0t got %h want %h", $time, (a), (e)); \
  end end
module scfm_core_tb;
  `include "scfm_exp.svh"
  logic ref_clk, rstn, cmdValid, cmdChanged, reqValid, reqHasFunc;
  logic reqAscii, reqThree, reqWrite, cmdSkip, cmdError, accValid;
  logic accWrite, accDone, accErr, dbValid, dbWrite, dbPend;
  logic [9:0] cmdCode, cmdElem, reqElem, fileSize, accElem;
  logic [1:0] cmdEnable;
  logic [15:0] cmdIntAddr, cmdCount, reqIntAddr, reqCount, accWdata;
  logic [15:0] accRdata, dbWdata, dbRdata, rnd, exd;
  logic [7:0] cmdNode, cmdFile, reqCmd, reqFunc, reqNode, reqFile, accFile;
  logic [6:0] firstFile;
  logic [3:0] accRegion;
  logic [17:0] accWord;
  logic [13:0] dbAddr;
  logic [80:0] qc[$], exc;
  logic [39:0] qa[$], exa;
  logic [15:0] qd[$], mem[int];
  int mismatches, comparisons;
  logic [9:0] codes [19] = '{10'h001, 10'h002, 10'h003, 10'h004,
    10'h005, 10'h064, 10'h065, 10'h066, 10'h096, 10'h097, 10'h098,
    10'h1f5, 10'h1f6, 10'h1fd, 10'h1fe, 10'h1ff, 10'h000, 10'h006,
    10'h1f7};
  logic [13:0] wl [12] = '{14'h0000, 14'h1387, 14'h1388, 14'h1392,
    14'h13b0, 14'h13ce, 14'h1450, 14'h1900, 14'h1db0, 14'h1e78,
    14'h1f40, 14'h270f};
  scfm_core u_scfm_core (.*);
  scfm_remote u_scfm_remote (.*);
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic finish_test();
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========
  // drivers, each noting its expected result
  task automatic cmd(input logic [9:0] c, input logic [1:0] en,
    input logic ch);
    logic w, hf;
    w = c inside {10'h001, [10'h003:10'h005], 10'h064, 10'h066, 10'h096,
      10'h098, [10'h1fd:10'h1ff]};
    hf = c > 10'h005;
    rnd = lfsr(rnd);
    cmdValid <= 1'b1;
    cmdCode <= c;
    cmdEnable <= en;
    cmdChanged <= ch;
    cmdNode <= rnd[7:0];
    cmdIntAddr <= rnd;
    cmdCount <= ~rnd;
    cmdFile <= rnd[15:8];
    cmdElem <= rnd[9:0];
    qc.push_back({!known(c) ? 3'b001 : (en == 2'h2 && !ch && w) ?
      3'b010 : 3'b100, cbyt(c), hf ? fbyt(c) : 8'h00, hf, rnd[7:0],
      w, c inside {10'h1f6, 10'h1fe, 10'h1ff}, c inside {[10'h096:10'h098]},
      rnd, ~rnd, rnd[15:8], rnd[9:0]});
    @(posedge ref_clk);
  endtask
  task automatic fa(input logic w, input logic [7:0] f,
    input logic [9:0] e, input int gap);
    logic [6:0] ff;
    logic [9:0] fs;
    logic [17:0] wd;
    logic bad;
    ff = (firstFile > 7'h64) ? 7'h07 : firstFile;
    fs = (fileSize == 10'h000 || fileSize > 10'h3e8) ? 10'h0c8 : fileSize;
    wd = (18'(f) - 18'(ff)) * 18'(fs) + 18'(e);
    bad = f < 8'(ff) || wd > 18'h0270f;
    rnd = lfsr(rnd);
    if (w && !bad) mem[wd] = rnd;
    qa.push_back({!w && !bad, bad, bad ? 4'hf : rgn(wd), wd,
      (!w && !bad) ? mem[wd] : 16'h0000});
    u_scfm_remote.acc(w, f, e, rnd, gap);
  endtask
  task automatic db(input logic w, input logic [13:0] a);
    rnd = lfsr(rnd);
    dbValid <= 1'b1;
    dbWrite <= w;
    dbAddr <= a;
    dbWdata <= rnd;
    if (w) mem[a] = rnd;
    else qd.push_back(mem[a]);
    @(posedge ref_clk);
  endtask
  // clock, 25 ns period
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // internal read pending one cycle
  always @(posedge ref_clk) dbPend <= dbValid && !dbWrite;
  // ==========
  // monitor takes the oldest note when a result shows
  always @(negedge ref_clk) begin
    if (rstn && (reqValid || cmdSkip || cmdError)) begin
      exc = qc.pop_front();
      `CHK({reqValid, cmdSkip, cmdError}, exc[80:78])
      if (reqValid) `CHK({reqCmd, reqFunc & {8{reqHasFunc}}, reqHasFunc, reqNode}, exc[77:53])
      if (reqValid) `CHK({reqWrite, reqThree, reqAscii}, exc[52:50])
      if (reqValid) `CHK({reqIntAddr, reqCount, reqFile, reqElem}, exc[49:0])
    end
    if (rstn && accDone) begin
      exa = qa.pop_front();
      `CHK({accErr, accRegion}, exa[38:34])
      if (!exa[38]) `CHK(accWord, exa[33:16])
      if (exa[39]) `CHK(accRdata, exa[15:0])
    end
    if (dbPend) begin
      exd = qd.pop_front();
      `CHK(dbRdata, exd)
    end
  end
  // ==========
  // main sequence
  initial begin
    {rstn, cmdValid, cmdCode, cmdEnable, cmdChanged, cmdIntAddr} = '0;
    {cmdCount, cmdNode, cmdFile, cmdElem, dbValid, dbWrite, dbAddr} = '0;
    {dbWdata, dbPend, mismatches, comparisons} = '0;
    firstFile = 7'h07;
    fileSize = 10'h0c8;
    rnd = 16'hb0e6;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    foreach (codes[i]) cmd(codes[i], 2'h1, 1'b1);
    cmd(10'h005, 2'h2, 1'b0);
    cmd(10'h064, 2'h2, 1'b0);
    cmd(10'h1fd, 2'h2, 1'b0);
    cmd(10'h002, 2'h2, 1'b0);
    cmd(10'h065, 2'h2, 1'b0);
    cmd(10'h005, 2'h2, 1'b1);
    cmdValid <= 1'b0;
    foreach (wl[i]) begin
      fa(1'b1, 8'(wl[i] / 14'h00c8 + 14'h0007), 10'(wl[i] % 14'h00c8), 0);
      fa(1'b0, 8'(wl[i] / 14'h00c8 + 14'h0007), 10'(wl[i] % 14'h00c8), 0);
    end
    fa(1'b0, 8'h39, 10'h000, 0);
    fa(1'b1, 8'h06, 10'h000, 1);
    fa(1'b1, 8'h09, 10'h005, 1);
    db(1'b0, 14'h0195);
    db(1'b1, 14'h0196);
    dbValid <= 1'b0;
    fa(1'b0, 8'h09, 10'h006, 1);
    firstFile <= 7'h00;
    fileSize <= 10'h3e8;
    @(posedge ref_clk);
    fa(1'b1, 8'h03, 10'h3e7, 0);
    fa(1'b0, 8'h03, 10'h3e7, 0);
    fa(1'b0, 8'h0a, 10'h000, 1);
    firstFile <= 7'h65;
    fileSize <= 10'h0c8;
    @(posedge ref_clk);
    fa(1'b1, 8'h09, 10'h004, 1);
    firstFile <= 7'h64;
    fileSize <= 10'h001;
    @(posedge ref_clk);
    fa(1'b1, 8'h9b, 10'h000, 0);
    fa(1'b0, 8'h9b, 10'h000, 1);
    repeat (3) @(posedge ref_clk);
    `CHK(qc.size() + qa.size() + qd.size(), 0)
    finish_test();
  end
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    finish_test();
  end
endmodule // scfm_core_tb
`default_nettype wire

// File: tb/scfm_exp.svh
// expected translation and area lookup for the bench side
// assumes inclusion inside a module body
function automatic logic [7:0] cbyt(logic [9:0] c);
  case (c)
    10'h001: return 8'h00;
    10'h002: return 8'h01;
    10'h003: return 8'h02;
    10'h004: return 8'h05;
    10'h005: return 8'h08;
    default: return 8'h0f;
  endcase
endfunction
function automatic logic [7:0] fbyt(logic [9:0] c);
  case (c)
    10'h064, 10'h096: return 8'h00;
    10'h065, 10'h097: return 8'h01;
    10'h066, 10'h098: return 8'h26;
    10'h1f5: return 8'ha1;
    10'h1f6: return 8'ha2;
    10'h1fd: return 8'ha9;
    10'h1fe: return 8'haa;
    default: return 8'hab;
  endcase
endfunction
function automatic logic known(logic [9:0] c);
  return c inside {[10'h001:10'h005], [10'h064:10'h066],
    [10'h096:10'h098], 10'h1f5, 10'h1f6, [10'h1fd:10'h1ff]};
endfunction
function automatic logic [3:0] rgn(logic [17:0] w);
  logic [13:0] b [9] = '{14'h1388, 14'h1392, 14'h13b0, 14'h13ce,
    14'h1450, 14'h1900, 14'h1db0, 14'h1e78, 14'h1f40};
  logic [3:0] r;
  r = 4'h0;
  foreach (b[i]) if (w >= 18'(b[i])) r = 4'(i + 1);
  return (w > 18'h0270f) ? 4'hf : r;
endfunction

// File: tb/scfm_remote.sv
// remote master model issuing file accesses
// assumes the caller enters its task at a rising edge
`timescale 1ns/1ps
`default_nettype none
module scfm_remote (
  input wire logic ref_clk, // clock
  output logic accValid, // access strobe
  output logic accWrite, // write flag
  output logic [7:0] accFile, // file number
  output logic [9:0] accElem, // element
  output logic [15:0] accWdata // write data
);
  // idle values at time zero
  initial begin
    accValid = 1'b0;
    accWrite = 1'b0;
    accFile = 8'h00;
    accElem = 10'h000;
    accWdata = 16'h0000;
  end
  task automatic acc(input logic w, input logic [7:0] f,
    input logic [9:0] e, input logic [15:0] d, input int gap);
    accValid <= 1'b1;
    accWrite <= w;
    accFile <= f;
    accElem <= e;
    accWdata <= d;
    @(posedge ref_clk);
    if (gap > 0) begin
      // released lines do not keep the last value
      accValid <= 1'b0;
      accWrite <= ~w;
      accFile <= ~f;
      accElem <= ~e;
      accWdata <= ~d;
      repeat (gap) @(posedge ref_clk);
    end
  endtask
endmodule // scfm_remote
`default_nettype wire
